// ===== rtl/mii_mac_pkg.sv
// Shared constants and types for the frame-level MII media access block.
package mii_mac_pkg;
	// Register byte offsets.
	localparam logic [15:0] OFF_TX_RAM = 16'h0000;
	localparam logic [15:0] OFF_RX_RAM = 16'h4000;
	localparam logic [15:0] OFF_DESC_RAM = 16'h8000;
	localparam logic [15:0] OFF_CMD = 16'hc000;
	localparam logic [15:0] OFF_STATUS = 16'hc004;
	localparam logic [15:0] OFF_TX_LEN = 16'hc008;
	localparam logic [15:0] OFF_TX_START = 16'hc00c;
	localparam logic [15:0] OFF_RX_DONE = 16'hc010;
	localparam logic [15:0] OFF_STA_LO = 16'hc014;
	localparam logic [15:0] OFF_STA_HI = 16'hc018;
	localparam logic [15:0] OFF_PHY_CTL = 16'hc01c;
	localparam logic [15:0] OFF_IRQ_CLR = 16'hc020;
	localparam logic [15:0] OFF_BUF_RP = 16'hc024;
	localparam logic [15:0] OFF_BUF_WP = 16'hc028;
	localparam logic [15:0] OFF_DSC_RP = 16'hc02c;
	localparam logic [15:0] OFF_DSC_WP = 16'hc030;
	localparam logic [15:0] OFF_RX_STATE = 16'hc034;
	localparam logic [15:0] OFF_TX_STATE = 16'hc038;
	localparam logic [15:0] OFF_IDENT = 16'hc03c;
	// General command bit positions.
	localparam int CMD_TX_EN = 0;
	localparam int CMD_RX_EN = 1;
	localparam int CMD_LOOP = 2;
	localparam int CMD_FILT = 3;
	localparam int CMD_UNI = 4;
	localparam int CMD_MULTI = 5;
	localparam int CMD_BCAST = 6;
	localparam int CMD_PROM = 7;
	// Transceiver control bit positions.
	localparam int PHY_RST = 0;
	localparam int PHY_MDI = 1;
	localparam int PHY_MDO = 2;
	localparam int PHY_MDOE = 3;
	localparam int PHY_MDC = 4;
	// Interrupt clear bit positions.
	localparam int CLR_TX = 0;
	localparam int CLR_RX = 4;
	// Descriptor field positions.
	localparam int DSC_CRC_ERR = 16;
	localparam int DSC_LEN_ERR = 17;
	localparam int DSC_SYM_ERR = 18;
	// Reset values.
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [10:0] TX_LEN_RESET = 11'h000;
	localparam logic [4:0] PHY_CTL_RESET = 5'h00;
	// Frame figures, in bytes or nibbles.
	localparam int TX_MAX_BYTES = 1514;
	localparam int RX_MIN_BYTES = 64;
	localparam int RX_MAX_BYTES = 1518;
	localparam int PRE_NIBBLES = 16;
	localparam int FCS_NIBBLES = 8;
	localparam int IFG_NIBBLES = 24;
	localparam logic [3:0] NIB_PRE = 4'h5;
	localparam logic [3:0] NIB_SFD = 4'hd;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	// One nibble of the media independent interface.
	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} nibble_t;
	typedef enum {T_IDLE, T_PRE, T_DATA, T_FCS, T_IFG} tx_state_t;
	typedef enum {R_IDLE, R_PRE, R_DATA, R_DROP} rx_state_t;
endpackage

// ===== rtl/mii_mac.sv
// Frame-level MII media access block with register port and on-chip frame stores.
`timescale 1ns/100ps
// Notes on behaviour
// - Full duplex MII, 10 or 100 Mbit/s.
// - No half duplex, jumbo or tagged frames.
// - Transmit store holds one largest frame.
// - Append frame check, insert inter-frame gap.
// - Receive store two frames, 48 descriptors.
// - Check length and CRC of arrivals.
// - Interrupts: received, transmitted, transceiver external.
// - Frame and descriptor stores at fixed offsets.
// - Command bits 0,1 enable transmit, receive.
// - Command bit 2 loops transmit into receive.
// - Command bit 3 discards errored frames.
// - Bits 4-7 unicast, multicast, broadcast, all.
// - Status bit 0 shows transmit active.
// - Status bits 7:1 count unread frames.
// - Transmit start write sends frame if command bit 0 set.
// - Receive done write decrements unread count.
// - Software lines for management and reset.
// - Receive and transmit states readable for debug.
// - Transceiver control bit layout.
// - Write one clears transmit or receive interrupt.
// - Pointers carry a rollover bit on wrap.
module mii_mac #(
	parameter int TX_WORDS = 379,
	parameter int BUF_WORDS = 1024,
	parameter int DESC_DEPTH = 48,
	parameter logic [31:0] IDENT_VALUE = 32'h00000001
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic mii_tx_clk,
	output logic [3:0] mii_txd,
	output logic mii_tx_en,
	input wire logic mii_rx_clk,
	input wire logic [3:0] mii_rxd,
	input wire logic mii_rx_dv,
	input wire logic mii_rx_er,
	input wire logic phy_int_n,
	output logic phy_rst_n,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	output logic mdc,
	output logic irq_rx,
	output logic irq_tx,
	output logic irq_phy
);
	// IDENT_VALUE is arbitrary.
	localparam int MAX_WORDS = (mii_mac_pkg::RX_MAX_BYTES + 3) / 4;

	function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ mii_mac_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [8:0] dsc_inc(input logic [8:0] p);
		return (p[7:0] == 8'(DESC_DEPTH - 1)) ? {~p[8], 8'h00} : p + 9'h001;
	endfunction

	// Pin inputs pass three flops; a bit changes once stages two and three agree.
	logic [9:0] pin_raw;
	logic [9:0] s1_q, s2_q, s3_q, flt_q;
	assign pin_raw = {mii_tx_clk, mii_rx_clk, phy_int_n, mdio_in, mii_rx_er, mii_rx_dv, mii_rxd};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 10'h080; // The interrupt pin idles high, so no false request follows reset.
			s2_q <= 10'h080;
			s3_q <= 10'h080;
			flt_q <= 10'h080;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
		end
	end
	// Link clocks are sampled, so 100 Mbit/s needs a system clock well above 50 MHz.
	wire tx_fall = ~s2_q[9] & ~s3_q[9] & flt_q[9];
	wire rx_rise = s2_q[8] & s3_q[8] & ~flt_q[8];

	// Register port decode.
	wire wr_tx_ram = wr && addr < mii_mac_pkg::OFF_RX_RAM;
	wire wr_cmd = wr && addr == mii_mac_pkg::OFF_CMD;
	wire wr_len = wr && addr == mii_mac_pkg::OFF_TX_LEN;
	wire wr_start = wr && addr == mii_mac_pkg::OFF_TX_START;
	wire wr_done = wr && addr == mii_mac_pkg::OFF_RX_DONE;
	wire wr_lo = wr && addr == mii_mac_pkg::OFF_STA_LO;
	wire wr_hi = wr && addr == mii_mac_pkg::OFF_STA_HI;
	wire wr_phy = wr && addr == mii_mac_pkg::OFF_PHY_CTL;
	wire wr_clr = wr && addr == mii_mac_pkg::OFF_IRQ_CLR;

	logic [7:0] cmd_q;
	logic [10:0] tx_len_q;
	logic [31:0] sta_lo_q;
	logic [15:0] sta_hi_q;
	logic [4:0] phy_q;
	// Software-written configuration.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= mii_mac_pkg::CMD_RESET;
			tx_len_q <= mii_mac_pkg::TX_LEN_RESET;
			sta_lo_q <= 32'h00000000;
			sta_hi_q <= 16'h0000;
			phy_q <= mii_mac_pkg::PHY_CTL_RESET;
		end else begin
			if (wr_cmd) cmd_q <= wdata[7:0];
			if (wr_len) tx_len_q <= wdata[10:0];
			if (wr_lo) sta_lo_q <= wdata;
			if (wr_hi) sta_hi_q <= wdata[15:0];
			if (wr_phy) phy_q <= wdata[4:0];
		end
	end
	// Management lines through one more flop stage after the register flops.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phy_rst_n <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
			mdc <= 1'b0;
			irq_phy <= 1'b0;
		end else begin
			phy_rst_n <= phy_q[mii_mac_pkg::PHY_RST];
			mdio_out <= phy_q[mii_mac_pkg::PHY_MDO];
			mdio_oe_n <= ~phy_q[mii_mac_pkg::PHY_MDOE];
			mdc <= phy_q[mii_mac_pkg::PHY_MDC];
			irq_phy <= ~flt_q[7];
		end
	end

	// Transmit store; software fills it before starting.
	logic [31:0] tx_mem [TX_WORDS];
	always_ff @(posedge clk_sys) begin
		if (wr_tx_ram && addr[13:2] < 12'(TX_WORDS)) tx_mem[addr[10:2]] <= wdata;
	end

	// Transmit sequencer, stepped on each falling edge of the link clock.
	mii_mac_pkg::tx_state_t tx_st_q, tx_st_d;
	logic [11:0] tx_cnt_q, tx_cnt_d;
	logic [31:0] tx_crc_q, tx_crc_d;
	logic start_q, tx_done_q;
	mii_mac_pkg::nibble_t tx_nib_d, tx_nib_q;
	logic tx_evt_q;
	logic [10:0] tx_bidx;
	logic [31:0] tx_word;
	logic [3:0] tx_data_nib;
	assign tx_bidx = tx_cnt_q[11:1];
	assign tx_word = tx_mem[tx_bidx[10:2]];
	assign tx_data_nib = 4'(tx_word >> {tx_bidx[1:0], tx_cnt_q[0], 2'b00});
	wire [11:0] tx_last = {tx_len_q, 1'b0} - 12'h001;

	always_comb begin
		tx_st_d = tx_st_q;
		tx_cnt_d = tx_cnt_q + 12'h001;
		tx_crc_d = tx_crc_q;
		tx_nib_d = '0;
		unique case (tx_st_q)
			mii_mac_pkg::T_IDLE: begin
				tx_cnt_d = 12'h000;
				if (start_q) tx_st_d = mii_mac_pkg::T_PRE;
			end
			mii_mac_pkg::T_PRE: begin
				tx_nib_d.dv = 1'b1;
				tx_nib_d.d = mii_mac_pkg::NIB_PRE;
				tx_crc_d = mii_mac_pkg::CRC_INIT;
				if (tx_cnt_q == 12'(mii_mac_pkg::PRE_NIBBLES - 1)) begin
					tx_nib_d.d = mii_mac_pkg::NIB_SFD;
					tx_cnt_d = 12'h000;
					tx_st_d = mii_mac_pkg::T_DATA;
				end
			end
			mii_mac_pkg::T_DATA: begin
				tx_nib_d.dv = 1'b1;
				tx_nib_d.d = tx_data_nib;
				tx_crc_d = crc_nib(tx_crc_q, tx_data_nib);
				if (tx_cnt_q == tx_last) begin
					tx_cnt_d = 12'h000;
					tx_st_d = mii_mac_pkg::T_FCS;
				end
			end
			mii_mac_pkg::T_FCS: begin
				tx_nib_d.dv = 1'b1;
				tx_nib_d.d = ~tx_crc_q[3:0];
				tx_crc_d = tx_crc_q >> 4;
				if (tx_cnt_q == 12'(mii_mac_pkg::FCS_NIBBLES - 1)) begin
					tx_cnt_d = 12'h000;
					tx_st_d = mii_mac_pkg::T_IFG;
				end
			end
			mii_mac_pkg::T_IFG: begin
				if (tx_cnt_q == 12'(mii_mac_pkg::IFG_NIBBLES - 1)) begin
					tx_st_d = mii_mac_pkg::T_IDLE;
				end
			end
		endcase
	end

	wire tx_finish = tx_fall && tx_st_q == mii_mac_pkg::T_IFG && tx_st_d == mii_mac_pkg::T_IDLE;
	// A start while a frame is in flight is held until the sequencer idles.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q <= mii_mac_pkg::T_IDLE;
			tx_cnt_q <= 12'h000;
			tx_crc_q <= mii_mac_pkg::CRC_INIT;
			start_q <= 1'b0;
			tx_nib_q <= '0;
			tx_evt_q <= 1'b0;
		end else begin
			if (wr_start && cmd_q[mii_mac_pkg::CMD_TX_EN]) start_q <= 1'b1;
			else if (tx_fall && tx_st_q == mii_mac_pkg::T_IDLE) start_q <= 1'b0;
			tx_evt_q <= tx_fall;
			if (tx_fall) begin
				tx_st_q <= tx_st_d;
				tx_cnt_q <= tx_cnt_d;
				tx_crc_q <= tx_crc_d;
				tx_nib_q <= tx_nib_d;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mii_txd <= 4'h0;
			mii_tx_en <= 1'b0;
		end else begin
			mii_txd <= tx_nib_q.d;
			mii_tx_en <= tx_nib_q.dv & ~cmd_q[mii_mac_pkg::CMD_LOOP];
		end
	end

	// Receive source: the pins, or the transmit nibbles when looping back.
	wire lb = cmd_q[mii_mac_pkg::CMD_LOOP];
	mii_mac_pkg::nibble_t pin_nib, rx_nib;
	assign pin_nib = '{dv: s3_q[4], er: s3_q[5], d: s3_q[3:0]};
	assign rx_nib = lb ? tx_nib_q : pin_nib;
	wire rx_stb = lb ? tx_evt_q : rx_rise;

	// Receive stores and pointers; bit above each index is the rollover.
	logic [7:0] rx_mem [BUF_WORDS * 4];
	logic [31:0] dsc_mem [DESC_DEPTH];
	logic [10:0] bwp_q, brp_q;
	logic [8:0] dwp_q, drp_q;
	logic [6:0] unread_frame_count;
	logic [10:0] used_words;
	assign used_words = bwp_q - brp_q;
	wire room = (11'(BUF_WORDS) - used_words >= 11'(MAX_WORDS))
		&& (unread_frame_count < 7'(DESC_DEPTH));

	mii_mac_pkg::rx_state_t rx_st_q;
	logic [11:0] rx_cnt_q;
	logic [31:0] rx_crc_q;
	logic rx_hi_q, rx_er_q, rx_ovf_q;
	logic [3:0] rx_lo_q;
	logic [47:0] dst_q;
	logic [11:0] rx_waddr;
	assign rx_waddr = {bwp_q[9:0], 2'b00} + rx_cnt_q;
	wire [7:0] rx_byte = {rx_nib.d, rx_lo_q};

	// End-of-frame evaluation.
	wire len_bad = rx_cnt_q < 12'(mii_mac_pkg::RX_MIN_BYTES) || rx_ovf_q || rx_hi_q;
	wire crc_bad = rx_crc_q != mii_mac_pkg::CRC_RESIDUE;
	wire frm_bad = len_bad | crc_bad | rx_er_q;
	wire is_bc = &dst_q;
	wire is_mc = dst_q[0] & ~is_bc;
	wire uc_hit = dst_q == {sta_hi_q, sta_lo_q};
	wire addr_ok = cmd_q[mii_mac_pkg::CMD_PROM] | (cmd_q[mii_mac_pkg::CMD_UNI] & uc_hit)
		| (cmd_q[mii_mac_pkg::CMD_MULTI] & is_mc) | (cmd_q[mii_mac_pkg::CMD_BCAST] & is_bc);
	wire frm_end = rx_stb && rx_st_q == mii_mac_pkg::R_DATA && !rx_nib.dv;
	wire keep = frm_end && addr_ok && !(cmd_q[mii_mac_pkg::CMD_FILT] && frm_bad);
	wire [31:0] dsc_word = {13'h0000, rx_er_q, len_bad, crc_bad, 5'h00, rx_cnt_q[10:0]};
	wire [10:0] frm_words = 11'((rx_cnt_q + 12'h003) >> 2);
	wire done_ok = wr_done && unread_frame_count != 7'h00;
	wire [11:0] rd_len = {1'b0, dsc_mem[drp_q[5:0]][10:0]};
	wire [10:0] rd_words = 11'((rd_len + 12'h003) >> 2);

	// Receive sequencer, stepped on each received nibble.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= mii_mac_pkg::R_IDLE;
			rx_cnt_q <= 12'h000;
			rx_crc_q <= mii_mac_pkg::CRC_INIT;
			rx_hi_q <= 1'b0;
			rx_er_q <= 1'b0;
			rx_ovf_q <= 1'b0;
			rx_lo_q <= 4'h0;
			dst_q <= 48'h0;
		end else if (rx_stb) begin
			unique case (rx_st_q)
				mii_mac_pkg::R_IDLE: begin
					if (rx_nib.dv && rx_nib.d == mii_mac_pkg::NIB_PRE) rx_st_q <= mii_mac_pkg::R_PRE;
				end
				mii_mac_pkg::R_PRE: begin
					rx_cnt_q <= 12'h000;
					rx_crc_q <= mii_mac_pkg::CRC_INIT;
					rx_hi_q <= 1'b0;
					rx_er_q <= 1'b0;
					rx_ovf_q <= 1'b0;
					if (!rx_nib.dv) rx_st_q <= mii_mac_pkg::R_IDLE;
					else if (rx_nib.d == mii_mac_pkg::NIB_SFD) begin
						rx_st_q <= (room && cmd_q[mii_mac_pkg::CMD_RX_EN]) ? mii_mac_pkg::R_DATA
							: mii_mac_pkg::R_DROP;
					end
				end
				mii_mac_pkg::R_DATA: begin
					if (!rx_nib.dv) rx_st_q <= mii_mac_pkg::R_IDLE;
					else begin
						rx_crc_q <= crc_nib(rx_crc_q, rx_nib.d);
						rx_hi_q <= ~rx_hi_q;
						rx_lo_q <= rx_nib.d;
						if (rx_nib.er) rx_er_q <= 1'b1;
						if (rx_hi_q) begin
							// Longer frames are cut and flagged; tagged and jumbo sizes fail.
							if (rx_cnt_q < 12'(mii_mac_pkg::RX_MAX_BYTES)) begin
								rx_cnt_q <= rx_cnt_q + 12'h001;
							end else rx_ovf_q <= 1'b1;
							if (rx_cnt_q < 12'h006) dst_q[rx_cnt_q[2:0] * 8 +: 8] <= rx_byte;
						end
					end
				end
				mii_mac_pkg::R_DROP: begin
					if (!rx_nib.dv) rx_st_q <= mii_mac_pkg::R_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rx_stb && rx_st_q == mii_mac_pkg::R_DATA && rx_nib.dv && rx_hi_q
			&& rx_cnt_q < 12'(mii_mac_pkg::RX_MAX_BYTES)) begin
			rx_mem[rx_waddr] <= rx_byte;
		end
		if (keep) dsc_mem[dwp_q[5:0]] <= dsc_word;
	end

	// Pointers, unread count and interrupt flags; a set beats a same-cycle clear.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bwp_q <= 11'h000;
			brp_q <= 11'h000;
			dwp_q <= 9'h000;
			drp_q <= 9'h000;
			unread_frame_count <= 7'h00;
			tx_done_q <= 1'b0;
			irq_rx <= 1'b0;
		end else begin
			if (keep) begin
				bwp_q <= bwp_q + frm_words;
				dwp_q <= dsc_inc(dwp_q);
			end
			if (done_ok) begin
				brp_q <= brp_q + rd_words;
				drp_q <= dsc_inc(drp_q);
			end
			unread_frame_count <= unread_frame_count + 7'(keep) - 7'(done_ok);
			if (tx_finish) tx_done_q <= 1'b1;
			else if (wr_clr && wdata[mii_mac_pkg::CLR_TX]) tx_done_q <= 1'b0;
			if (keep) irq_rx <= 1'b1;
			else if (wr_clr && wdata[mii_mac_pkg::CLR_RX]) irq_rx <= 1'b0;
		end
	end
	assign irq_tx = tx_done_q;

	// Read selection; unmapped and write-only addresses read zero.
	wire tx_busy = start_q || tx_st_q != mii_mac_pkg::T_IDLE;
	wire in_rx_ram = addr >= mii_mac_pkg::OFF_RX_RAM && addr < mii_mac_pkg::OFF_DESC_RAM;
	wire in_dsc = addr >= mii_mac_pkg::OFF_DESC_RAM && addr[13:2] < 12'(DESC_DEPTH);
	wire [11:0] rxa = {addr[11:2], 2'b00};
	wire [31:0] rx_ram_word = {rx_mem[rxa + 12'h003], rx_mem[rxa + 12'h002],
		rx_mem[rxa + 12'h001], rx_mem[rxa]};
	wire [31:0] rd_mux =
		in_rx_ram ? rx_ram_word :
		(in_dsc && addr < mii_mac_pkg::OFF_CMD) ? dsc_mem[addr[7:2]] :
		addr == mii_mac_pkg::OFF_CMD ? {24'h0, cmd_q} :
		addr == mii_mac_pkg::OFF_STATUS ? {24'h0, unread_frame_count, tx_busy} :
		addr == mii_mac_pkg::OFF_TX_LEN ? {21'h0, tx_len_q} :
		addr == mii_mac_pkg::OFF_STA_LO ? sta_lo_q :
		addr == mii_mac_pkg::OFF_STA_HI ? {16'h0, sta_hi_q} :
		addr == mii_mac_pkg::OFF_PHY_CTL ? {30'h0, flt_q[6], 1'b0} :
		addr == mii_mac_pkg::OFF_BUF_RP ? {21'h0, brp_q} :
		addr == mii_mac_pkg::OFF_BUF_WP ? {21'h0, bwp_q} :
		addr == mii_mac_pkg::OFF_DSC_RP ? {23'h0, drp_q} :
		addr == mii_mac_pkg::OFF_DSC_WP ? {23'h0, dwp_q} :
		addr == mii_mac_pkg::OFF_RX_STATE ? 32'(rx_st_q) :
		addr == mii_mac_pkg::OFF_TX_STATE ? 32'(tx_st_q) :
		addr == mii_mac_pkg::OFF_IDENT ? IDENT_VALUE : 32'h00000000;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) rdata <= 32'h00000000;
		else if (rd) rdata <= rd_mux;
		else rdata <= 32'h00000000;
	end
endmodule // mii_mac

// ===== dv/mii_mac_asserts.sv
// Concurrent checks on the port behaviour of the MII media access block.
`timescale 1ns/100ps
module mii_mac_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en,
	input wire logic phy_int_n,
	input wire logic phy_rst_n,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	input wire logic mdc,
	input wire logic irq_rx,
	input wire logic irq_tx,
	input wire logic irq_phy
);
	logic [10:0] len_q;
	logic [15:0] run_q;
	logic loop_q;
	// Register decodes seen by the helper logic and the properties.
	wire cmd_w = wr && addr == mii_mac_pkg::OFF_CMD;
	wire len_w = wr && addr == mii_mac_pkg::OFF_TX_LEN;
	wire clr_w = wr && addr == mii_mac_pkg::OFF_IRQ_CLR;
	wire ctl_w = wr && addr == mii_mac_pkg::OFF_PHY_CTL;
	wire wo_rd = rd && (addr == mii_mac_pkg::OFF_TX_START || addr == mii_mac_pkg::OFF_RX_DONE);
	// Shadow the length and loopback bit, and time each burst of transmit enable.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			len_q <= mii_mac_pkg::TX_LEN_RESET;
			loop_q <= 1'b0;
			run_q <= 16'h0000;
		end else begin
			len_q <= len_w ? wdata[10:0] : len_q;
			loop_q <= cmd_w ? wdata[mii_mac_pkg::CMD_LOOP] : loop_q;
			run_q <= mii_tx_en ? run_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence pre_run;
		(mii_txd == mii_mac_pkg::NIB_PRE) [*8];
	endsequence
	// The pins lag a control write by two cycles: one for the register, one for the pin flops.
	sequence ctl_landed;
		##2 (phy_rst_n == $past(wdata[mii_mac_pkg::PHY_RST], 2)
			&& mdio_out == $past(wdata[mii_mac_pkg::PHY_MDO], 2)
			&& mdio_oe_n == !$past(wdata[mii_mac_pkg::PHY_MDOE], 2)
			&& mdc == $past(wdata[mii_mac_pkg::PHY_MDC], 2));
	endsequence
	property ctl_pins;
		ctl_w |-> ctl_landed;
	endproperty
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside answer");
	wo_read_a: assert property (wo_rd |=> rdata == 32'h0)
		else $error("write-only place read non-zero");
	ctl_pins_a: assert property (ctl_pins)
		else $error("transceiver pins differ from control write");
	tx_clear_a: assert property (clr_w && wdata[mii_mac_pkg::CLR_TX] |=> !irq_tx)
		else $error("transmit irq not cleared");
	rx_clear_a: assert property (clr_w && wdata[mii_mac_pkg::CLR_RX] |=> !irq_rx)
		else $error("receive irq not cleared");
	tx_keep_a: assert property (clr_w && !wdata[mii_mac_pkg::CLR_TX] && irq_tx |=> irq_tx)
		else $error("transmit irq lost");
	preamble_start_a: assert property ($rose(mii_tx_en) |-> pre_run)
		else $error("frame does not open with preamble");
	frame_span_a: assert property ($fell(mii_tx_en) |-> run_q == (24 + 2 * len_q) * 8)
		else $error("frame span wrong");
	loop_quiet_a: assert property (loop_q |-> !mii_tx_en)
		else $error("transmit enable active in loopback");
	phy_irq_on_a: assert property (!phy_int_n [*6] |-> irq_phy)
		else $error("transceiver irq missing");
	phy_irq_off_a: assert property (phy_int_n [*6] |-> !irq_phy)
		else $error("transceiver irq stuck");
endmodule // mii_mac_asserts

// ===== dv/mii_phy_model.sv
// Behavioural transceiver: link clocks, transmit capture and receive replay.
`timescale 1ns/100ps
module mii_phy_model (
	output logic mii_tx_clk,
	output logic mii_rx_clk,
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_rx_er
);
	logic [3:0] cap[$];
	// Both clocks run at 160 ns with unrelated phases; a real transceiver never stops them.
	initial begin
		mii_rx_clk = 1'b0;
		mii_rxd = 4'ha;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		#37;
		forever #80 mii_rx_clk = ~mii_rx_clk;
	end
	// The transmit clock has a process of its own, so it has a single driver.
	initial begin
		mii_tx_clk = 1'b0;
		forever #80 mii_tx_clk = ~mii_tx_clk;
	end
	// Nibbles are taken at the first rising edge after the block moves them, so they are settled.
	always @(posedge mii_tx_clk) begin
		if (mii_tx_en === 1'b1) begin
			cap.push_back(mii_txd);
		end
	end
	// Replay the captured stream; a flipped data nibble spoils the check sequence.
	task automatic send(input bit bad);
		for (int i = 0; i < cap.size(); i++) begin
			@(negedge mii_rx_clk);
			mii_rx_dv <= 1'b1;
			mii_rxd <= (bad && i == 40) ? ~cap[i] : cap[i];
		end
		@(negedge mii_rx_clk);
		mii_rx_dv <= 1'b0;
		mii_rxd <= ~mii_rxd; // Idle data must not look like the last nibble.
		repeat (4) @(negedge mii_rx_clk);
	endtask
endmodule // mii_phy_model

// ===== dv/frame_level_mii_mac_tb.sv
// Self-checking bench for the MII media access block.
`timescale 1ns/100ps
bind mii_mac mii_mac_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
	.phy_int_n(phy_int_n), .phy_rst_n(phy_rst_n), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
	.mdc(mdc), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_phy(irq_phy));
module frame_level_mii_mac_tb;
	logic clk_sys = 1'b0;
	logic rst_n, wr, rd, mii_tx_clk, mii_rx_clk, mii_tx_en, mii_rx_dv, mii_rx_er;
	logic [15:0] addr;
	logic [31:0] wdata, rdata, d, f;
	logic [3:0] mii_txd, mii_rxd;
	logic phy_int_n, phy_rst_n, mdio_in, mdio_out, mdio_oe_n, mdc, irq_rx, irq_tx, irq_phy;
	int n_errors = 0;
	int n_compared = 0;
	always #10 clk_sys = ~clk_sys;
	mii_mac dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
		.mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
		.phy_int_n(phy_int_n), .phy_rst_n(phy_rst_n), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .mdc(mdc), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_phy(irq_phy));
	mii_phy_model phy (.mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk), .mii_txd(mii_txd),
		.mii_tx_en(mii_tx_en), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er));
	// Test frame: broadcast destination, then a byte ramp.
	function automatic logic [7:0] fb(input int i);
		return (i < 6) ? 8'hff : i[7:0];
	endfunction
	// Reflected check sequence over the first n frame bytes, complemented for the wire.
	function automatic logic [31:0] fcs_of(input int n);
		logic [31:0] c;
		c = mii_mac_pkg::CRC_INIT;
		for (int i = 0; i < n; i++) begin
			c = c ^ {24'h0, fb(i)};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ mii_mac_pkg::CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// The answer stands only in the cycle after the strobe, so it is taken just past that edge.
	task automatic rreg(input logic [15:0] a);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		rreg(a);
		chk(d, exp);
	endtask
	task automatic wait_tx();
		for (int k = 0; k < 4000 && irq_tx !== 1'b1; k++) @(posedge clk_sys);
		chk({31'h0, irq_tx}, 32'h1);
	endtask
	task automatic rx_frame(input logic [31:0] cmd, input bit bad, input logic [31:0] st);
		wreg(mii_mac_pkg::OFF_CMD, cmd);
		phy.send(bad);
		repeat (8) @(posedge clk_sys);
		rchk(mii_mac_pkg::OFF_STATUS, st);
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d compared", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under half of this span.
	initial begin
		#1_000_000;
		n_errors++;
		tally_and_finish();
	end
	// Main sequence: reset values, registers, pins, transmit, receive, filters, loopback.
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 32'h0;
		phy_int_n = 1'b1;
		mdio_in = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(mii_mac_pkg::OFF_STATUS, 32'h0);
		rchk(mii_mac_pkg::OFF_TX_LEN, 32'h0);
		rchk(mii_mac_pkg::OFF_STA_LO, 32'h0);
		rchk(mii_mac_pkg::OFF_STA_HI, 32'h0);
		rchk(mii_mac_pkg::OFF_BUF_WP, 32'h0);
		rchk(mii_mac_pkg::OFF_DSC_RP, 32'h0);
		chk({30'h0, phy_rst_n, mdio_oe_n}, 32'h1);
		wreg(mii_mac_pkg::OFF_CMD, 32'hfc);
		rchk(mii_mac_pkg::OFF_CMD, 32'hfc);
		wreg(mii_mac_pkg::OFF_TX_LEN, 32'h5ea);
		rchk(mii_mac_pkg::OFF_TX_LEN, 32'h5ea);
		wreg(mii_mac_pkg::OFF_STA_LO, 32'h44332211);
		rchk(mii_mac_pkg::OFF_STA_LO, 32'h44332211);
		wreg(mii_mac_pkg::OFF_STA_HI, 32'h6655);
		rchk(mii_mac_pkg::OFF_STA_HI, 32'h6655);
		rchk(mii_mac_pkg::OFF_TX_START, 32'h0);
		rchk(16'hc040, 32'h0);
		rchk(mii_mac_pkg::OFF_TX_STATE, 32'h0);
		rchk(mii_mac_pkg::OFF_RX_STATE, 32'h0);
		mdio_in <= 1'b1;
		wreg(mii_mac_pkg::OFF_PHY_CTL, 32'h1d);
		repeat (4) @(posedge clk_sys);
		chk({28'h0, phy_rst_n, mdc, mdio_out, mdio_oe_n}, 32'he);
		rchk(mii_mac_pkg::OFF_PHY_CTL, 32'h2);
		wreg(mii_mac_pkg::OFF_PHY_CTL, 32'h1);
		phy_int_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk({31'h0, irq_phy}, 32'h1);
		phy_int_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk({31'h0, irq_phy}, 32'h0);
		// A start with transmit disabled must be ignored.
		wreg(mii_mac_pkg::OFF_CMD, 32'h0);
		wreg(mii_mac_pkg::OFF_TX_START, 32'h0);
		rchk(mii_mac_pkg::OFF_STATUS, 32'h0);
		for (int i = 0; i < 15; i++) begin
			wreg(mii_mac_pkg::OFF_TX_RAM + 16'(4 * i), {fb(4*i+3), fb(4*i+2), fb(4*i+1), fb(4*i)});
		end
		wreg(mii_mac_pkg::OFF_TX_LEN, 32'd60);
		wreg(mii_mac_pkg::OFF_CMD, 32'h43);
		wreg(mii_mac_pkg::OFF_TX_START, 32'h0);
		rchk(mii_mac_pkg::OFF_STATUS, 32'h1);
		repeat (16) @(posedge clk_sys);
		rchk(mii_mac_pkg::OFF_TX_STATE, 32'h1);
		wait_tx();
		chk(32'(phy.cap.size()), 32'd144);
		chk({28'h0, phy.cap[15]}, {28'h0, mii_mac_pkg::NIB_SFD});
		for (int i = 0; i < 60; i++) begin
			chk({24'h0, phy.cap[17+2*i], phy.cap[16+2*i]}, {24'h0, fb(i)});
		end
		f = fcs_of(60);
		for (int k = 0; k < 8; k++) chk({28'h0, phy.cap[136+k]}, {28'h0, f[4*k+:4]});
		rchk(mii_mac_pkg::OFF_STATUS, 32'h0);
		wreg(mii_mac_pkg::OFF_IRQ_CLR, 32'h1);
		#1;
		chk({31'h0, irq_tx}, 32'h0);
		// Receive: replay the sent frame, then errored and filtered copies.
		rx_frame(32'h43, 1'b0, 32'h2);
		chk({31'h0, irq_rx}, 32'h1);
		rchk(mii_mac_pkg::OFF_RX_RAM, 32'hffffffff);
		rchk(mii_mac_pkg::OFF_RX_RAM + 16'h8, {fb(11), fb(10), fb(9), fb(8)});
		rreg(mii_mac_pkg::OFF_DESC_RAM);
		chk(d & 32'h000707ff, 32'd64);
		rchk(mii_mac_pkg::OFF_BUF_WP, 32'd16);
		rchk(mii_mac_pkg::OFF_DSC_WP, 32'd1);
		rx_frame(32'h4b, 1'b1, 32'h2);
		rx_frame(32'h33, 1'b0, 32'h2);
		rx_frame(32'h83, 1'b0, 32'h4);
		rx_frame(32'h81, 1'b0, 32'h4);
		wreg(mii_mac_pkg::OFF_RX_DONE, 32'h0);
		rchk(mii_mac_pkg::OFF_STATUS, 32'h2);
		rchk(mii_mac_pkg::OFF_BUF_RP, 32'd16);
		wreg(mii_mac_pkg::OFF_IRQ_CLR, 32'h10);
		#1;
		chk({31'h0, irq_rx}, 32'h0);
		// Loopback: the frame returns inside, transmit enable stays low.
		phy.cap.delete();
		wreg(mii_mac_pkg::OFF_CMD, 32'h47);
		wreg(mii_mac_pkg::OFF_TX_START, 32'h0);
		wait_tx();
		repeat (16) @(posedge clk_sys);
		chk(32'(phy.cap.size()), 32'd0);
		rchk(mii_mac_pkg::OFF_STATUS, 32'h4);
		chk({31'h0, irq_rx}, 32'h1);
		wreg(mii_mac_pkg::OFF_IRQ_CLR, 32'h10);
		#1;
		chk({30'h0, irq_tx, irq_rx}, 32'h2);
		wreg(mii_mac_pkg::OFF_IRQ_CLR, 32'h1);
		#1;
		chk({31'h0, irq_tx}, 32'h0);
		tally_and_finish();
	end
endmodule // frame_level_mii_mac_tb
